// *** hdl/isp_slave.sv ***
// What this block does
// R1 - only 7-bit addresses; eighth bit picks write (0) or read (1)
// R2 - answer 0x48 with select high, 0x40 with it low, plus 0x49
// R3 - any other target address is left unacknowledged
// R4 - eight-bit registers; first byte after write address is the pointer
// R5 - write bytes land at pointer, pointer then steps up; with the update buffer full an in-bank byte is refused and the pointer held
// R6 - read bytes come from pointer, pointer steps for each further byte
// R7 - master makes every clock pulse; clock line never driven low here
// R8 - works at any clock rate up to 3.4MHz, including long pauses
// R9 - one bit per clock; data stable while clock is high
// R10 - data change while clock high is a bus condition, not data
// R11 - nine pulses per byte, msb first, then acknowledge
// R12 - data fall with clock high is start, data rise is stop
// R13 - idle bus leaves both lines released high
// R14 - repeated start behaves as a fresh start, address follows
// R15 - after stop or wrong address, ignore clock until next start
// R16 - acknowledge drives data low through ninth pulse high phase
// R17 - not-acknowledge leaves data released through ninth pulse
// R18 - master ends reads with not-acknowledge then stop
// R19 - every pointer value is acknowledged, holes included
// R20 - master should retry later after missing acknowledge
// R21 - all-zero broadcast address is not acknowledged
// R22 - written byte commits at data rise after its acknowledge slot, or at the next byte's eighth clock rise if the data line never rises
// R23 - stop leaves the pointer untouched
// R24 - lines are synchronised and conditions found from clean levels
// R25 - holes read zero; writes to them are dropped silently
`timescale 1ns/1ns
`default_nettype none
`include "isp_consts.svh"

module isp_slave
    import isp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic addrSel,
    input wire logic updReady,
    output logic sdaOut,
    output logic sdaOe,
    output logic sclOut,
    output logic sclOe,
    output logic updValid,
    output isp_byte_t updAddr,
    output isp_byte_t updData
);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // bit 0 clock, bit 1 data, bit 2 address select
    logic [2:0] pinS1_q;
    logic [2:0] pinS2_q;
    logic [2:0] pinS3_q;
    logic [2:0] pinLvl_q;
    logic [2:0] pinPrev_q;
    wire [2:0] pinAgree = ~(pinS2_q ^ pinS3_q);
    wire [2:0] pinLvl_d = (pinS3_q & pinAgree) | (pinLvl_q & ~pinAgree);

    // a level only moves once the last two stages agree
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pinS1_q <= `ISP_PIN_IDLE;
            pinS2_q <= `ISP_PIN_IDLE;
            pinS3_q <= `ISP_PIN_IDLE;
            pinLvl_q <= `ISP_PIN_IDLE;
            pinPrev_q <= `ISP_PIN_IDLE;
        end else begin
            pinS1_q <= {addrSel, sdaIn, sclIn};
            pinS2_q <= pinS1_q;
            pinS3_q <= pinS2_q;
            pinLvl_q <= pinLvl_d; // R24
            pinPrev_q <= pinLvl_q;
        end
    end

    // ----------------------------------------
    // edge and condition decode
    // ----------------------------------------
    wire sclLvl = pinLvl_q[0];
    wire sdaLvl = pinLvl_q[1];
    wire selLvl = pinLvl_q[2];
    wire sclHeld = sclLvl && pinPrev_q[0];
    wire sclRise = sclLvl && !pinPrev_q[0];
    wire sclFall = !sclLvl && pinPrev_q[0];
    wire sdaRise = sdaLvl && !pinPrev_q[1];
    wire sdaFall = !sdaLvl && pinPrev_q[1];
    // data moving under a high clock is never a data bit
    wire startCond = sclHeld && sdaFall; // R10 R12
    wire stopCond = sclHeld && sdaRise; // R10 R12

    // ----------------------------------------
    // sequencer state
    // ----------------------------------------
    isp_state_t state_q, state_d;
    logic [3:0] bitCnt_q, bitCnt_d;
    isp_byte_t shift_q, shift_d;
    isp_byte_t ptr_q, ptr_d;
    isp_byte_t pendPtr_q, pendPtr_d;
    isp_byte_t pendData_q, pendData_d;
    logic isRead_q, isRead_d;
    logic havePtr_q, havePtr_d;
    logic pend_q, pend_d;
    logic mAck_q, mAck_d;
    logic sdaOe_q, sdaOe_d;

    isp_mem_if memBus ();

    // ----------------------------------------
    // address match and byte bookkeeping
    // ----------------------------------------
    wire [6:0] mainAddr = selLvl ? `ISP_ADDR_MAIN_HI : `ISP_ADDR_MAIN_LO;
    // zero never matches, so broadcast stays unanswered
    wire addrHit = (shift_q[7:1] == mainAddr)
                || (shift_q[7:1] == `ISP_ADDR_TEST); // R2 R3 R21
    wire byteFull = (bitCnt_q == `ISP_BITS_PER_BYTE);
    wire ptrInBank = {1'b0, ptr_q} < `ISP_REG_COUNT;
    // a master letting go early inside our slot is not the commit edge
    wire inAckOut = (state_q == ST_ACK_OUT);
    wire [7:0] ptrInc = 8'(ptr_q + 8'h01);
    wire [3:0] bitInc = 4'(bitCnt_q + 4'h1);
    // last data bit of the next byte in flight
    wire lastBitIn = sclRise && (state_q == ST_RECV)
                  && (bitCnt_q == 4'h7);
    // commit waits for the data rise; a held-low line would otherwise
    // let the next byte overwrite it, so the next byte forces it out
    wire commitNow = pend_q && ((sdaRise && !inAckOut) || lastBitIn); // R22
    wire [1:0] bufCnt;
    wire bufFull = (bufCnt == `ISP_BUF_DEPTH);

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        bitCnt_d = bitCnt_q;
        shift_d = shift_q;
        ptr_d = ptr_q;
        pendPtr_d = pendPtr_q;
        pendData_d = pendData_q;
        isRead_d = isRead_q;
        havePtr_d = havePtr_q;
        pend_d = pend_q && !commitNow;
        mAck_d = mAck_q;
        sdaOe_d = sdaOe_q;
        if (stopCond) begin
            // pointer survives the stop
            state_d = ST_IDLE; // R15 R23
            sdaOe_d = 1'b0; // R13
        end else if (startCond) begin
            state_d = ST_ADDR; // R14
            bitCnt_d = 4'h0;
            havePtr_d = 1'b0;
            sdaOe_d = 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    // clock ignored until a start
                    state_d = ST_IDLE; // R15
                end
                ST_ADDR, ST_RECV: begin
                    if (sclRise && !byteFull) begin
                        shift_d = {shift_q[6:0], sdaLvl}; // R9 R11
                        bitCnt_d = bitInc;
                    end else if (sclFall && byteFull) begin
                        bitCnt_d = 4'h0;
                        if (state_q == ST_ADDR) begin
                            if (addrHit) begin
                                isRead_d = shift_q[0]; // R1
                                sdaOe_d = 1'b1; // R16
                                state_d = ST_ACK_OUT;
                            end else begin
                                state_d = ST_IDLE; // R3 R15
                            end
                        end else if (!havePtr_q) begin
                            ptr_d = shift_q; // R4
                            havePtr_d = 1'b1;
                            sdaOe_d = 1'b1; // R19
                            state_d = ST_ACK_OUT;
                        end else if (ptrInBank && bufFull) begin
                            // no room to report it, so refuse the byte
                            sdaOe_d = 1'b0; // R17
                            state_d = ST_ACK_OUT;
                        end else begin
                            pend_d = ptrInBank; // R25
                            pendPtr_d = ptr_q;
                            pendData_d = shift_q;
                            ptr_d = ptrInc; // R5
                            sdaOe_d = 1'b1; // R16
                            state_d = ST_ACK_OUT;
                        end
                    end
                end
                ST_ACK_OUT: begin
                    if (sclFall && isRead_q) begin
                        shift_d = memBus.rdData; // R6
                        sdaOe_d = !memBus.rdData[7]; // R11
                        state_d = ST_SEND;
                    end else if (sclFall) begin
                        sdaOe_d = 1'b0;
                        state_d = ST_RECV;
                    end
                end
                ST_SEND: begin
                    if (sclRise) begin
                        bitCnt_d = bitInc;
                    end else if (sclFall && byteFull) begin
                        bitCnt_d = 4'h0;
                        sdaOe_d = 1'b0; // R17
                        state_d = ST_ACK_IN;
                    end else if (sclFall) begin
                        shift_d = {shift_q[6:0], 1'b0};
                        sdaOe_d = !shift_q[6]; // R9 R11
                    end
                end
                ST_ACK_IN: begin
                    if (sclRise) begin
                        mAck_d = !sdaLvl;
                        ptr_d = sdaLvl ? ptr_q : ptrInc; // R6
                    end else if (sclFall && mAck_q) begin
                        shift_d = memBus.rdData;
                        sdaOe_d = !memBus.rdData[7];
                        state_d = ST_SEND;
                    end else if (sclFall) begin
                        // released until the closing stop
                        state_d = ST_IDLE; // R18
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // sequencer registers
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            bitCnt_q <= 4'h0;
            shift_q <= 8'h00;
            isRead_q <= 1'b0;
            havePtr_q <= 1'b0;
            mAck_q <= 1'b0;
            sdaOe_q <= 1'b0;
        end else begin
            state_q <= state_d;
            bitCnt_q <= bitCnt_d;
            shift_q <= shift_d;
            isRead_q <= isRead_d;
            havePtr_q <= havePtr_d;
            mAck_q <= mAck_d;
            sdaOe_q <= sdaOe_d;
        end
    end

    // pointer and pending write kept apart from the sequencer
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ptr_q <= 8'h00;
            pend_q <= 1'b0;
            pendPtr_q <= 8'h00;
            pendData_q <= 8'h00;
        end else begin
            ptr_q <= ptr_d;
            pend_q <= pend_d;
            pendPtr_q <= pendPtr_d;
            pendData_q <= pendData_d;
        end
    end

    // ----------------------------------------
    // register bank
    // ----------------------------------------
    assign memBus.wrEn = commitNow; // R22
    assign memBus.wrAddr = pendPtr_q;
    assign memBus.wrData = pendData_q;
    assign memBus.rdAddr = ptr_q;

    isp_reg_mem u_mem (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .bus(memBus.mem)
    );

    // ----------------------------------------
    // update buffer, two entries
    // ----------------------------------------
    isp_upd_t buf_q [2];
    logic wrSlot_q;
    logic rdSlot_q;
    logic [1:0] bufCnt_q;
    wire bufPush = commitNow;
    wire bufPop = updValid && updReady;
    wire [1:0] cntUp = 2'(bufCnt_q + 2'h1);
    wire [1:0] cntDn = 2'(bufCnt_q - 2'h1);
    wire [1:0] bufCnt_d = (bufPush && !bufPop) ? cntUp
                        : (bufPop && !bufPush) ? cntDn : bufCnt_q;

    // a full buffer turns in-bank data bytes away, so no update is lost
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            buf_q[0] <= '0;
            buf_q[1] <= '0;
            wrSlot_q <= 1'b0;
            rdSlot_q <= 1'b0;
            bufCnt_q <= 2'h0;
        end else begin
            if (bufPush) begin
                buf_q[wrSlot_q] <= {pendPtr_q, pendData_q};
                wrSlot_q <= !wrSlot_q;
            end
            if (bufPop) begin
                rdSlot_q <= !rdSlot_q;
            end
            bufCnt_q <= bufCnt_d;
        end
    end

    assign bufCnt = bufCnt_q;
    assign updValid = (bufCnt_q != 2'h0);
    assign updAddr = buf_q[rdSlot_q].addr;
    assign updData = buf_q[rdSlot_q].data;

    // ----------------------------------------
    // line drivers
    // ----------------------------------------
    // open drain: only ever pull low; clock is never touched
    assign sdaOut = 1'b0; // R16
    assign sdaOe = sdaOe_q;
    assign sclOut = 1'b0;
    assign sclOe = 1'b0; // R7 R8

endmodule : isp_slave

`default_nettype wire

// *** hdl/isp_consts.svh ***
`ifndef ISP_CONSTS_SVH
`define ISP_CONSTS_SVH

// ----------------------------------------
// target addresses
// ----------------------------------------
`define ISP_ADDR_MAIN_HI 7'h48
`define ISP_ADDR_MAIN_LO 7'h40
`define ISP_ADDR_TEST 7'h49

// ----------------------------------------
// framing and register bank
// ----------------------------------------
`define ISP_BITS_PER_BYTE 4'h8
`define ISP_REG_COUNT 9'h010
`define ISP_BUF_DEPTH 2'h2
`define ISP_PIN_IDLE 3'h7

`endif

// *** hdl/isp_pkg.sv ***
package isp_pkg;

    // bus-side sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_RECV,
        ST_ACK_OUT,
        ST_SEND,
        ST_ACK_IN
    } isp_state_t;

    typedef logic [7:0] isp_byte_t;

    // one entry of the update buffer
    typedef struct packed {
        isp_byte_t addr;
        isp_byte_t data;
    } isp_upd_t;

endpackage : isp_pkg

// *** hdl/isp_mem_if.sv ***
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// register bank port
// ----------------------------------------
interface isp_mem_if;
    logic wrEn;
    logic [7:0] wrAddr;
    logic [7:0] wrData;
    logic [7:0] rdAddr;
    logic [7:0] rdData;

    modport ctrl (output wrEn, output wrAddr, output wrData,
                  output rdAddr, input rdData);
    modport mem (input wrEn, input wrAddr, input wrData,
                 input rdAddr, output rdData);
endinterface : isp_mem_if

`default_nettype wire

// *** hdl/isp_reg_mem.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "isp_consts.svh"

module isp_reg_mem
    import isp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    isp_mem_if.mem bus
);

    // ----------------------------------------
    // storage
    // ----------------------------------------
    isp_byte_t regs_q [16];
    isp_byte_t rdData_q;

    wire wrHit = bus.wrEn && ({1'b0, bus.wrAddr} < `ISP_REG_COUNT);
    wire rdHit = {1'b0, bus.rdAddr} < `ISP_REG_COUNT;

    // writes outside the bank vanish, nothing else moves
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < 16; i++) begin
                regs_q[i] <= 8'h00;
            end
        end else if (wrHit) begin
            regs_q[bus.wrAddr[3:0]] <= bus.wrData; // R25
        end
    end

    // registered read; holes read as zero
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdData_q <= 8'h00;
        end else begin
            rdData_q <= rdHit ? regs_q[bus.rdAddr[3:0]] : 8'h00; // R25
        end
    end

    assign bus.rdData = rdData_q;

endmodule : isp_reg_mem

`default_nettype wire

// *** verification/isp_slave_properties.sv ***
`timescale 1ns/1ns
`default_nettype none

module isp_slave_properties
    import isp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic updReady,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic sclOut,
    input wire logic sclOe,
    input wire logic updValid,
    input wire isp_byte_t updAddr,
    input wire isp_byte_t updData
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // ----
    // raw line watch
    // ----
    logic sclP_q;
    logic sdaP_q;
    logic idle_q;
    logic [4:0] hiCnt_q;
    wire logic stopSeen = sclIn && sclP_q && sdaIn && !sdaP_q;
    wire logic startSeen = sclIn && sclP_q && !sdaIn && sdaP_q;

    // raw pins, so the design's own synchroniser delay is never borrowed
    always_ff @(posedge sys_clk) begin
        sclP_q <= sclIn;
        sdaP_q <= sdaIn;
        if (sys_rst || stopSeen) idle_q <= 1'b1;
        else if (startSeen) idle_q <= 1'b0;
        if (sys_rst || !sclIn) hiCnt_q <= 5'h00;
        else if (hiCnt_q != 5'h1F) hiCnt_q <= hiCnt_q + 5'h01;
    end

    // ----
    // assertions
    // ----
    a_no_clk_stretch: assert property (!sclOe && !sclOut)
        else $error("clock line pulled");
    a_sda_open_drain: assert property (sdaOe |-> !sdaOut)
        else $error("data line driven high");
    a_sda_moves_low: assert property ($changed(sdaOe) |-> !sclIn)
        else $error("data drive moved in high phase");
    a_ack_holds: assert property ($rose(sdaOe) |-> sdaOe [*8])
        else $error("data drive too short");
    a_quiet_after_stop: assert property (idle_q |-> !sdaOe)
        else $error("drive between stop and start");
    a_sync_delay: assert property ($fell(sclIn) |=> $stable(sdaOe) [*2])
        else $error("reacted to unsynchronised clock");
    a_idle_release: assert property (hiCnt_q >= 5'h0C |-> !sdaOe)
        else $error("drive on idle bus");
    a_upd_hold: assert property (updValid && !updReady |=>
        updValid && $stable(updAddr) && $stable(updData))
        else $error("update word lost under stall");

    cov_ack: cover property ($rose(sdaOe) && !sclIn);
    cov_upd: cover property ($rose(updValid));
    cov_stall: cover property (updValid && !updReady);
endmodule : isp_slave_properties

bind isp_slave isp_slave_properties u_isp_slave_properties (.sys_clk,
    .sys_rst, .sclIn, .sdaIn, .updReady, .sdaOut, .sdaOe, .sclOut, .sclOe,
    .updValid, .updAddr, .updData);

`default_nettype wire

// *** verification/isp_master_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module isp_master_model
    import isp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sdaLine,
    output logic scl,
    output logic sdaDrv
);
    // ----
    // bus master, 160 ns bit, clock stands high between frames
    // ----
    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end

    task automatic wt(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : wt

    // data moves late in the low phase, after the slave lets go
    task automatic bit_x(input logic b, output logic s);
        wt(6);
        sdaDrv = b;
        wt(2);
        scl = 1'b1;
        wt(4);
        s = sdaLine;
        wt(4);
        scl = 1'b0;
    endtask : bit_x

    task automatic start_c;
        wt(4);
        sdaDrv = 1'b1;
        wt(4);
        scl = 1'b1;
        wt(8);
        sdaDrv = 1'b0;
        wt(8);
        scl = 1'b0;
    endtask : start_c

    task automatic stop_c;
        wt(6);
        sdaDrv = 1'b0;
        wt(2);
        scl = 1'b1;
        wt(8);
        sdaDrv = 1'b1;
        wt(8);
    endtask : stop_c

    task automatic send(input isp_byte_t b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(b[i], s);
        bit_x(1'b1, s);
        ack = !s;
    endtask : send

    task automatic recv(input logic more, output isp_byte_t d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, s);
            d[i] = s;
        end
        bit_x(!more, s);
    endtask : recv
endmodule : isp_master_model

`default_nettype wire

// *** verification/isp_slave_bench.sv ***
`timescale 1ns/1ns
`default_nettype none

module isp_slave_bench
    import isp_pkg::*;
;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic addrSel = 1'b1;
    logic updReady = 1'b0;
    logic sclM, sdaM, sdaOut, sdaOe, sclOut, sclOe, updValid;
    isp_byte_t updAddr, updData;
    // open-drain lines with pull-ups
    wire logic sclIn = sclM & !sclOe;
    wire logic sdaIn = sdaM & !sdaOe;
    int err_count, check_count, cyc;

    always #5 sys_clk = ~sys_clk;

    isp_slave u_isp_slave (.sys_clk, .sys_rst, .sclIn, .sdaIn, .addrSel,
        .updReady, .sdaOut, .sdaOe, .sclOut, .sclOe, .updValid, .updAddr,
        .updData);
    isp_master_model u_isp_master_model (.sys_clk, .sdaLine(sdaIn),
        .scl(sclM), .sdaDrv(sdaM));

    // ----
    // helpers
    // ----
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    // generous ceiling: the whole run needs about 5500 cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic snd(input isp_byte_t b, input logic e);
        logic a;
        u_isp_master_model.send(b, a);
        chk({7'h00, a}, {7'h00, e});
    endtask : snd

    task automatic rcv(input logic more, input isp_byte_t e);
        isp_byte_t d;
        u_isp_master_model.recv(more, d);
        chk(d, e);
    endtask : rcv

    // checks the oldest update word, then pops it
    task automatic pop(input isp_byte_t a, input isp_byte_t d);
        chk({7'h00, updValid}, 8'h01);
        chk(updAddr, a);
        chk(updData, d);
        @(negedge sys_clk) updReady = 1'b1;
        @(negedge sys_clk) updReady = 1'b0;
    endtask : pop

    // ----
    // scenarios
    // ----
    task automatic t_addr;
        logic [6:0] ad [7] = '{7'h48, 7'h40, 7'h49, 7'h00, 7'h50,
                               7'h40, 7'h48};
        logic [6:0] selV = 7'b0011111;
        logic [6:0] expV = 7'b0100101;
        for (int i = 0; i < 7; i++) begin
            @(negedge sys_clk) addrSel = selV[i];
            u_isp_master_model.wt(8);
            u_isp_master_model.start_c();
            snd({ad[i], 1'b0}, expV[i]);
            if (!expV[i]) snd(8'h92, 1'b0);
            u_isp_master_model.stop_c();
        end
        addrSel = 1'b1;
        $display("t_addr done");
    endtask : t_addr

    task automatic t_write_stall;
        u_isp_master_model.start_c();
        snd(8'h90, 1'b1);
        snd(8'h0D, 1'b1);
        snd(8'hA1, 1'b1);
        // low msb: no rise at the slot end, so this byte's third-bit rise commits the write
        snd(8'h32, 1'b1);
        // two updates queued, in-bank byte refused, pointer held
        snd(8'hC3, 1'b0);
        u_isp_master_model.stop_c();
        pop(8'h0D, 8'hA1);
        pop(8'h0E, 8'h32);
        chk({7'h00, updValid}, 8'h00);
        $display("t_write_stall done");
    endtask : t_write_stall

    task automatic t_read_burst;
        u_isp_master_model.start_c();
        snd(8'h90, 1'b1);
        snd(8'h0D, 1'b1);
        u_isp_master_model.start_c();
        snd(8'h91, 1'b1);
        rcv(1'b1, 8'hA1);
        rcv(1'b1, 8'h32);
        rcv(1'b1, 8'h00);
        rcv(1'b0, 8'h00);
        u_isp_master_model.stop_c();
        $display("t_read_burst done");
    endtask : t_read_burst

    task automatic t_wrap;
        u_isp_master_model.start_c();
        snd(8'h90, 1'b1);
        snd(8'hFF, 1'b1);
        snd(8'h77, 1'b1);
        u_isp_master_model.wt(300);
        snd(8'h5A, 1'b1);
        u_isp_master_model.stop_c();
        pop(8'h00, 8'h5A);
        chk({7'h00, updValid}, 8'h00);
        u_isp_master_model.start_c();
        snd(8'h90, 1'b1);
        snd(8'h00, 1'b1);
        u_isp_master_model.stop_c();
        u_isp_master_model.start_c();
        snd(8'h93, 1'b1);
        rcv(1'b0, 8'h5A);
        u_isp_master_model.stop_c();
        $display("t_wrap done");
    endtask : t_wrap

    initial begin
        repeat (10) @(negedge sys_clk);
        sys_rst = 1'b0;
        repeat (8) @(negedge sys_clk);
        t_addr();
        t_write_stall();
        t_read_burst();
        t_wrap();
        give_verdict();
    end
endmodule : isp_slave_bench

`default_nettype wire
